// ---- rtl/flash_bus_cycle.sv ----
// one asynchronous flash bus cycle (word write or word read) on the flash pins
// assumes sys_clk at 20 MHz; data pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_bus_cycle (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe
);
  import flash_host_pkg::*;

  localparam int unsigned WP_CYC = ns_min_cyc(`FH_T_WP_NS);
  localparam int unsigned WPH_CYC = ns_min_cyc(`FH_T_WPH_NS);
  // two extra cycles cover the input synchroniser
  localparam int unsigned RD_CYC = ns_min_cyc(`FH_T_ACC_NS) + 2;
  localparam int unsigned OEHP_CYC = ns_min_cyc(`FH_T_OEHP_NS);

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} bc_state_e;

  bc_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [19:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_q, dq_oe_d;
  logic [15:0] dq_meta_q, dq_sync_q;

  always_ff @(posedge sys_clk) begin
    dq_meta_q <= flash_dq_in;
    dq_sync_q <= dq_meta_q;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (state_q)
      BC_IDLE: if (start) begin
        state_d = BC_SETUP;
        wr_d = wr;
        addr_d = addr;
        wdata_d = wdata;
      end
      BC_SETUP: begin
        state_d = BC_STROBE;
        cnt_d = wr_q ? 4'(WP_CYC - 1) : 4'(RD_CYC - 1);
      end
      BC_STROBE: if (cnt_q == 4'h0) begin
        state_d = BC_RECOVER;
        cnt_d = wr_q ? 4'(WPH_CYC - 1) : 4'(OEHP_CYC - 1);
        if (!wr_q) rdata_d = dq_sync_q;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      BC_RECOVER: if (cnt_q == 4'h0) begin
        state_d = BC_IDLE;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
    endcase
    ce_n_d = !(state_d == BC_SETUP || state_d == BC_STROBE);
    // output enable never falls in a write cycle
    oe_n_d = !(state_d == BC_STROBE && !wr_d);
    we_n_d = !(state_d == BC_STROBE && wr_d);
    dq_oe_d = wr_d && state_d != BC_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= BC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  assign done = done_q;
  assign rdata = rdata_q;
  assign flash_addr = addr_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_we_n = we_n_q;
  assign flash_dq_out = wdata_q;
  assign flash_dq_oe = dq_oe_q;

  property p_oe_high_in_write;
    @(posedge sys_clk) disable iff (rst) (!flash_ce_n && !flash_we_n) |-> flash_oe_n;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low during write strobe");

  property p_read_strobe_len;
    @(posedge sys_clk) disable iff (rst) $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n)[*4] ##1 flash_oe_n;
  endproperty
  a_read_strobe_len: assert property (p_read_strobe_len) else $error("read strobe not four cycles");

endmodule : flash_bus_cycle

// ---- rtl/flash_host_ctrl.sv ----
// host-side controller for an asynchronous 16-bit flash: reads, program, erase, id, lockdown
// assumes one request at a time from logic on sys_clk; flash pins are asynchronous
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_host_ctrl #(
  parameter int unsigned SECTOR_TMO_CYC = int'(((`FH_T_SEC2_S > `FH_T_SEC1_S) ? `FH_T_SEC2_S : `FH_T_SEC1_S)
                                          * `FH_CLK_HZ),
  parameter int unsigned CHIP_TMO_CYC = int'(`FH_T_EC_S * `FH_CLK_HZ)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input flash_host_pkg::op_e cmd_op,
  input wire logic [19:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic dual_mode,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_timeout,
  output logic busy,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe
);
  import flash_host_pkg::*;

  localparam int unsigned RP_CYC = ns_min_cyc(`FH_T_RP_NS);
  localparam int unsigned PROG_TMO_CYC = us_max_cyc(`FH_T_BP_US);
  localparam int unsigned DUAL_TMO_CYC = us_max_cyc(`FH_T_BPD_US);

  typedef enum logic [2:0] {M_RESET, M_IDLE, M_ISSUE, M_WAIT, M_POLL_ISSUE, M_POLL_WAIT, M_RESP} main_state_e;

  // sequence steps come from step_of in the package
  main_state_e state_q, state_d;
  op_e op_q, op_d;
  logic [19:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic [2:0] step_q, step_d;
  logic [3:0] rst_cnt_q, rst_cnt_d;
  logic [31:0] tmo_cnt_q, tmo_cnt_d, tmo_lim_q, tmo_lim_d;
  logic prev_q, prev_d, have_prev_q, have_prev_d;
  logic [15:0] rdata_q, rdata_d;
  logic timeout_q, timeout_d;
  logic reset_n_q, reset_n_d;
  logic bus_start, bus_done;
  logic [15:0] bus_rdata;
  logic tbit;
  step_s cur;

  assign cur = step_of(op_q, step_q, addr_q, data_q);
  assign tbit = bus_rdata[`FH_TOGGLE_BIT];
  assign bus_start = (state_q == M_ISSUE) || (state_q == M_POLL_ISSUE);
  assign cmd_ready = (state_q == M_IDLE);

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    step_d = step_q;
    rst_cnt_d = rst_cnt_q;
    tmo_cnt_d = tmo_cnt_q;
    tmo_lim_d = tmo_lim_q;
    prev_d = prev_q;
    have_prev_d = have_prev_q;
    rdata_d = rdata_q;
    timeout_d = timeout_q;
    unique case (state_q)
      // reset pulse leaves the device in array read
      M_RESET: if (rst_cnt_q == 4'h0) state_d = M_IDLE;
        else rst_cnt_d = rst_cnt_q - 4'h1;
      M_IDLE: if (cmd_valid) begin
        state_d = M_ISSUE;
        op_d = cmd_op;
        addr_d = cmd_addr;
        data_d = cmd_data;
        step_d = 3'd0;
        timeout_d = 1'b0;
        unique case (cmd_op)
          OP_PROGRAM: tmo_lim_d = dual_mode ? DUAL_TMO_CYC : PROG_TMO_CYC;
          OP_SECTOR_ERASE: tmo_lim_d = SECTOR_TMO_CYC;
          default: tmo_lim_d = CHIP_TMO_CYC;
        endcase
      end
      M_ISSUE: state_d = M_WAIT;
      M_WAIT: if (bus_done) begin
        if (cur.rd) rdata_d = bus_rdata;
        if (!cur.last) begin
          step_d = step_q + 3'd1;
          state_d = M_ISSUE;
        end else if (cur.poll) begin
          addr_d = cur.a;
          have_prev_d = 1'b0;
          tmo_cnt_d = 32'h00000000;
          state_d = M_POLL_ISSUE;
        end else begin
          state_d = M_RESP;
        end
      end
      M_POLL_ISSUE: begin
        tmo_cnt_d = tmo_cnt_q + 32'h1;
        state_d = M_POLL_WAIT;
      end
      M_POLL_WAIT: begin
        tmo_cnt_d = tmo_cnt_q + 32'h1;
        if (bus_done) begin
          prev_d = tbit;
          have_prev_d = 1'b1;
          rdata_d = bus_rdata;
          if (have_prev_q && tbit == prev_q) begin
            state_d = M_RESP;
          end else if (tmo_cnt_q >= tmo_lim_q) begin
            timeout_d = 1'b1;
            state_d = M_RESP;
          end else begin
            state_d = M_POLL_ISSUE;
          end
        end
      end
      M_RESP: state_d = M_IDLE;
    endcase
    reset_n_d = (state_d != M_RESET);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= M_RESET;
      op_q <= OP_READ;
      addr_q <= 20'h00000;
      data_q <= 16'h0000;
      step_q <= 3'd0;
      rst_cnt_q <= 4'(RP_CYC - 1);
      tmo_cnt_q <= 32'h00000000;
      tmo_lim_q <= 32'h00000000;
      prev_q <= 1'b0;
      have_prev_q <= 1'b0;
      rdata_q <= 16'h0000;
      timeout_q <= 1'b0;
      reset_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      step_q <= step_d;
      rst_cnt_q <= rst_cnt_d;
      tmo_cnt_q <= tmo_cnt_d;
      tmo_lim_q <= tmo_lim_d;
      prev_q <= prev_d;
      have_prev_q <= have_prev_d;
      rdata_q <= rdata_d;
      timeout_q <= timeout_d;
      reset_n_q <= reset_n_d;
    end
  end

  assign rsp_valid = (state_q == M_RESP);
  assign rsp_data = rdata_q;
  assign rsp_timeout = timeout_q;
  assign busy = (state_q != M_IDLE);
  assign flash_reset_n = reset_n_q;

  flash_bus_cycle flash_bus_cycle_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(bus_start),
    .wr(!cur.rd && state_q == M_ISSUE),
    .addr(state_q == M_POLL_ISSUE ? addr_q : cur.a),
    .wdata(cur.d),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  property p_chip_final;
    @(posedge sys_clk) disable iff (rst) (state_q == M_ISSUE && op_q == OP_CHIP_ERASE && cur.last)
      |=> flash_addr == 20'h00555 && flash_dq_out == 16'h0010 ##1 !flash_we_n;
  endproperty
  a_chip_final: assert property (p_chip_final) else $error("chip erase final write wrong");

  property p_sector_final;
    @(posedge sys_clk) disable iff (rst) (state_q == M_ISSUE && op_q == OP_SECTOR_ERASE && cur.last)
      |=> flash_dq_out == 16'h0030 && flash_addr == $past(addr_q);
  endproperty
  a_sector_final: assert property (p_sector_final) else $error("sector erase final write wrong");

  property p_sector_addr;
    @(posedge sys_clk) disable iff (rst) (state_q == M_WAIT && op_q == OP_SECTOR_ERASE && cur.last && bus_done)
      |=> state_q == M_POLL_ISSUE && addr_q == $past(addr_q);
  endproperty
  a_sector_addr: assert property (p_sector_addr) else $error("sector address lost");

  property p_poll_addr;
    @(posedge sys_clk) disable iff (rst) (state_q == M_POLL_ISSUE) |=> flash_addr == $past(addr_q) && !flash_ce_n;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");

  property p_id_addr;
    @(posedge sys_clk) disable iff (rst) (state_q == M_ISSUE && op_q == OP_ID_READ && step_q == 3'd3)
      |=> flash_addr[19:1] == 19'h00000 && flash_addr[0] == $past(addr_q[0]) ##1 !flash_oe_n;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id read address wrong");

  property p_upper_byte_zero;
    @(posedge sys_clk) disable iff (rst) (!flash_we_n && !(op_q == OP_PROGRAM && step_q == 3'd3))
      |-> flash_dq_out[15:8] == 8'h00;
  endproperty
  a_upper_byte_zero: assert property (p_upper_byte_zero) else $error("command upper byte not zero");

  property p_reset_pulse;
    @(posedge sys_clk) disable iff (rst) $rose(flash_reset_n) |-> !$past(flash_reset_n, 10) && cmd_ready;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("flash reset pulse too short");

  property p_done_on_equal;
    @(posedge sys_clk) disable iff (rst) (state_q == M_POLL_WAIT && bus_done && have_prev_q && tbit == prev_q)
      |=> rsp_valid && !rsp_timeout ##1 cmd_ready;
  endproperty
  a_done_on_equal: assert property (p_done_on_equal) else $error("poll did not complete on equal bits");

  property p_in_order;
    @(posedge sys_clk) disable iff (rst) (state_q == M_WAIT && bus_done && !cur.last)
      |=> state_q == M_ISSUE && step_q == $past(step_q) + 3'd1;
  endproperty
  a_in_order: assert property (p_in_order) else $error("command step skipped");

  property p_prog_limit;
    @(posedge sys_clk) disable iff (rst) (state_q == M_POLL_ISSUE && op_q == OP_PROGRAM)
      |-> tmo_lim_q == 32'd4000 || tmo_lim_q == 32'd2000;
  endproperty
  a_prog_limit: assert property (p_prog_limit) else $error("program timeout limit wrong");

  c_chip_done: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && op_q == OP_CHIP_ERASE && !rsp_timeout);
  c_prog_done: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && op_q == OP_PROGRAM && !rsp_timeout);
  c_id_read: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && op_q == OP_ID_READ);
  c_timeout: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && rsp_timeout);

endmodule : flash_host_ctrl

// ---- rtl/flash_host_pkg.sv ----
// types and cycle arithmetic for the flash host controller
// assumes the constants header is on the include path
package flash_host_pkg;
`include "flash_host_regs.svh"

  typedef enum logic [2:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_ID_READ, OP_LOCKDOWN} op_e;

  typedef struct packed {
    logic rd;
    logic [19:0] a;
    logic [15:0] d;
    logic last;
    logic poll;
  } step_s;

  // least times round up, never below one cycle
  function automatic int unsigned ns_min_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * (`FH_CLK_HZ / 1000000) + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : ns_min_cyc

  // longest times round down
  function automatic int unsigned us_max_cyc(input int unsigned us);
    return us * (`FH_CLK_HZ / 1000000);
  endfunction : us_max_cyc

  // unlock pair then command: 555/aa, 2aa/55, 555/cmd; upper byte always zero
  function automatic logic [35:0] unlock_word(input logic [1:0] k, input logic [7:0] cmd);
    unique case (k)
      2'd0: return {`FH_ADDR_555, 8'h00, `FH_UNLOCK_D1};
      2'd1: return {`FH_ADDR_2AA, 8'h00, `FH_UNLOCK_D2};
      default: return {`FH_ADDR_555, 8'h00, cmd};
    endcase
  endfunction : unlock_word

  // one step of each sequence, strictly in order, writes only until the end except the id read at step 3
  function automatic step_s step_of(input op_e op, input logic [2:0] n, input logic [19:0] a,
                                    input logic [15:0] d);
    step_s s;
    s = '{rd: 1'b0, a: `FH_ADDR_555, d: 16'h0000, last: 1'b0, poll: 1'b0};
    unique case (op)
      OP_READ: begin
        s.rd = 1'b1;
        s.a = a;
        s.last = 1'b1;
      end
      OP_PROGRAM: if (n < 3'd3) begin
        {s.a, s.d} = unlock_word(n[1:0], `FH_CMD_PROGRAM);
      end else begin
        s.a = a;
        s.d = d;
        s.last = 1'b1;
        s.poll = 1'b1;
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_LOCKDOWN: if (n < 3'd3) begin
        {s.a, s.d} = unlock_word(n[1:0], `FH_CMD_ERASE);
      end else if (n < 3'd5) begin
        {s.a, s.d} = unlock_word(2'(n - 3'd3), 8'h00);
      end else begin
        s.last = 1'b1;
        if (op == OP_SECTOR_ERASE) begin
          s.a = a;
          s.d = {8'h00, `FH_CMD_SECTOR_ERASE};
          s.poll = 1'b1;
        end else if (op == OP_CHIP_ERASE) begin
          s.a = `FH_ADDR_555;
          s.d = {8'h00, `FH_CMD_CHIP_ERASE};
          s.poll = 1'b1;
        end else begin
          s.d = {8'h00, `FH_CMD_LOCKDOWN};
        end
      end
      OP_ID_READ: if (n < 3'd3) begin
        {s.a, s.d} = unlock_word(n[1:0], `FH_CMD_ID_ENTRY);
      end else if (n == 3'd3) begin
        s.rd = 1'b1;
        s.a = {19'h00000, a[0]};
      end else begin
        // leave id mode before returning, back to array read
        {s.a, s.d} = unlock_word(2'(n - 3'd4), `FH_CMD_ID_EXIT);
        s.last = (n == 3'd6);
      end
    endcase
    return s;
  endfunction : step_of

endpackage : flash_host_pkg

// ---- rtl/flash_host_regs.svh ----
// constants for the flash host controller: command codes, addresses, timings
// assumes a 16-bit asynchronous flash with 20 address bits on the far side
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

`define FH_CLK_HZ 20000000

`define FH_ADDR_555 20'h00555
`define FH_ADDR_2AA 20'h002aa
`define FH_UNLOCK_D1 8'haa
`define FH_UNLOCK_D2 8'h55
`define FH_CMD_PROGRAM 8'ha0
`define FH_CMD_ERASE 8'h80
`define FH_CMD_CHIP_ERASE 8'h10
`define FH_CMD_SECTOR_ERASE 8'h30
`define FH_CMD_ID_ENTRY 8'h90
`define FH_CMD_ID_EXIT 8'hf0
`define FH_CMD_LOCKDOWN 8'h60

`define FH_TOGGLE_BIT 6

`define FH_T_WP_NS 35
`define FH_T_WPH_NS 35
`define FH_T_ACC_NS 70
`define FH_T_OEHP_NS 50
`define FH_T_RP_NS 500
`define FH_T_BP_US 200
`define FH_T_BPD_US 100
`define FH_T_SEC1_S 3.0
`define FH_T_SEC2_S 5.0
`define FH_T_EC_S 25

`endif

// ---- verification/flash_dev_model.sv ----
// behavioural flash device seen from the host: command decode, array, toggle status, id codes
// assumes registered host pins; strobe edges are sampled 1 ns late so all pins have settled
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0a5a, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0b6b, // arbitrary value
  parameter int SECTOR_LSB = 15
) (
  input wire logic [19:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [15:0] flash_dq_in,
  input wire logic [15:0] busy_len
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] kq [$];
  logic [11:0] ha [0:5];
  logic [7:0] hd [0:5];
  logic [15:0] rd_q = 16'h0000;
  logic [19:0] poll_a;
  logic [19:0] erase_addr;
  logic tog = 1'b0, prog_arm = 1'b0, id_mode = 1'b0, lock_en = 1'b0, poll_set = 1'b0;
  int busy_cnt = 0, erase_kind = 0, viol_oe = 0, viol_seq = 0, viol_addr = 0;
  // no pull on the bus: a released bus shows the inverse of the last word
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : (!flash_ce_n && !flash_oe_n) ? rd_q : ~rd_q;
  function automatic logic unl(input int i);
    return ha[i] == 12'h555 && hd[i] == 8'haa && ha[i+1] == 12'h2aa && hd[i+1] == 8'h55;
  endfunction : unl
  always @(negedge flash_we_n) begin
    #1;
    if (!flash_ce_n) begin
      if (!flash_oe_n) viol_oe++;
      if (prog_arm) begin
        mem[flash_addr] = (mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff) & flash_dq_out;
        prog_arm = 1'b0;
        busy_cnt = busy_len;
        poll_set = 1'b0;
      end else begin
        for (int i = 0; i < 5; i++) begin
          ha[i] = ha[i+1];
          hd[i] = hd[i+1];
        end
        ha[5] = flash_addr[11:0];
        hd[5] = flash_dq_out[7:0];
        if (unl(3) && ha[5] == 12'h555 && hd[5] == 8'ha0) prog_arm = 1'b1;
        if (unl(3) && ha[5] == 12'h555 && hd[5] == 8'h90) id_mode = 1'b1;
        if (hd[5] == 8'hf0) id_mode = 1'b0;
        if (unl(0) && ha[2] == 12'h555 && hd[2] == 8'h80 && unl(3)) begin
          if (hd[5] == 8'h60 && ha[5] == 12'h555) lock_en = 1'b1;
          if ((hd[5] == 8'h10 && ha[5] == 12'h555) || hd[5] == 8'h30) begin
            erase_kind = (hd[5] == 8'h10) ? 2 : 1;
            erase_addr = flash_addr;
            kq = {};
            foreach (mem[k]) if (erase_kind == 2 || k[19:SECTOR_LSB] == flash_addr[19:SECTOR_LSB]) kq.push_back(k);
            foreach (kq[j]) mem.delete(kq[j]);
            busy_cnt = busy_len;
            poll_set = 1'b0;
          end
        end
      end
    end
  end
  always @(negedge flash_oe_n) begin
    #1;
    if (!flash_ce_n) begin
      if (busy_cnt == 0 && (prog_arm || hd[5] == 8'h80 || (hd[5] == 8'haa && ha[5] == 12'h555)
          || (hd[5] == 8'h55 && ha[5] == 12'h2aa))) viol_seq++;
      if (busy_cnt > 0) begin
        if (poll_set && flash_addr != poll_a) viol_addr++;
        poll_a = flash_addr;
        poll_set = 1'b1;
        tog = ~tog;
        busy_cnt--;
        rd_q = {9'h000, tog, 6'h00};
      end else if (id_mode && flash_addr[19:1] == 19'h0) rd_q = flash_addr[0] ? PART_CODE : MAKER_CODE;
      else rd_q = mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff;
    end
  end
  always @(negedge flash_reset_n) begin
    id_mode = 1'b0;
    busy_cnt = 0;
    prog_arm = 1'b0;
  end
endmodule : flash_dev_model

// ---- verification/test_flash_host_ctrl.sv ----
// self-checking bench: flash host controller driving the behavioural flash model
// assumes the package, constants header and flash model are compiled before this file
`timescale 1ns/1ps
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, dual_mode = 1'b0, got_tmo;
  op_e cmd_op = OP_READ;
  logic [19:0] cmd_addr = 20'h00000, flash_addr;
  logic [15:0] cmd_data = 16'h0000, busy_len = 16'h0000, rsp_data, flash_dq_in, flash_dq_out, got;
  logic cmd_ready, rsp_valid, rsp_timeout, busy, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe;
  int error_cnt = 0, n_compared = 0;
  always #25 sys_clk = ~sys_clk;
  // short poll limits keep timeouts reachable in simulation
  flash_host_ctrl #(.SECTOR_TMO_CYC(200), .CHIP_TMO_CYC(400)) flash_host_ctrl_inst (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .dual_mode(dual_mode), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .busy(busy),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
  flash_dev_model flash_dev_model_inst (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .busy_len(busy_len));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // entered just after a rising edge; levels are sampled mid-cycle
  task automatic req(input op_e op, input logic [19:0] a, input logic [15:0] d, input logic dm, input logic [15:0] bl);
    int n;
    busy_len <= bl;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    dual_mode <= dm;
    cmd_valid <= 1'b1;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 100);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 20000);
    chk("response", n < 20000, 1);
    chk("busy at response", busy, 1'b1);
    got = rsp_data;
    got_tmo = rsp_timeout;
    @(posedge sys_clk);
  endtask : req
  task automatic do_reset();
    int n;
    rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("flash reset pin", flash_reset_n, 1'b0);
    chk("ready in reset", cmd_ready, 1'b0);
    n = 0;
    do begin @(negedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 30);
    chk("reset pulse long enough", n >= 10 && n < 30, 1);
    chk("idle after reset", busy, 1'b0);
    chk("array mode after reset", flash_dev_model_inst.id_mode, 1'b0);
    @(posedge sys_clk);
  endtask : do_reset
  task automatic t_program();
    req(OP_PROGRAM, 20'h12345, 16'h5a3c, 1'b0, 16'd5);
    chk("program timeout", got_tmo, 1'b0);
    chk("status polls left", flash_dev_model_inst.busy_cnt, 0);
    req(OP_READ, 20'h12345, 16'h0000, 1'b0, 16'd0);
    chk("program readback", got, 16'h5a3c);
  endtask : t_program
  task automatic t_dual();
    req(OP_PROGRAM, 20'h00100, 16'h1234, 1'b1, 16'd300);
    chk("dual program limit", got_tmo, 1'b1);
    do_reset();
    req(OP_PROGRAM, 20'h00101, 16'h1234, 1'b0, 16'd300);
    chk("single program limit", got_tmo, 1'b0);
  endtask : t_dual
  task automatic t_sector();
    req(OP_PROGRAM, 20'h18002, 16'h0001, 1'b0, 16'd3);
    req(OP_PROGRAM, 20'h20000, 16'h0002, 1'b0, 16'd3);
    req(OP_SECTOR_ERASE, 20'h1abcd, 16'h0000, 1'b0, 16'd10);
    chk("sector erase timeout", got_tmo, 1'b0);
    chk("erase kind", flash_dev_model_inst.erase_kind, 1);
    chk("sector address", flash_dev_model_inst.erase_addr, 20'h1abcd);
    req(OP_READ, 20'h18002, 16'h0000, 1'b0, 16'd0);
    chk("erased word", got, 16'hffff);
    req(OP_READ, 20'h20000, 16'h0000, 1'b0, 16'd0);
    chk("other sector kept", got, 16'h0002);
    req(OP_SECTOR_ERASE, 20'h00010, 16'h0000, 1'b0, 16'd1000);
    chk("stalled sector erase", got_tmo, 1'b1);
    do_reset();
  endtask : t_sector
  task automatic t_chip();
    // 30 polls outlast the sector limit but not the chip limit
    req(OP_CHIP_ERASE, 20'h54321, 16'h0000, 1'b0, 16'd30);
    chk("chip erase timeout", got_tmo, 1'b0);
    chk("erase kind", flash_dev_model_inst.erase_kind, 2);
    chk("chip erase address", flash_dev_model_inst.erase_addr, 20'h00555);
    req(OP_READ, 20'h20000, 16'h0000, 1'b0, 16'd0);
    chk("chip erased word", got, 16'hffff);
    req(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0, 16'd1000);
    chk("stalled chip erase", got_tmo, 1'b1);
    do_reset();
  endtask : t_chip
  task automatic t_id();
    req(OP_ID_READ, 20'h00000, 16'h0000, 1'b0, 16'd0);
    chk("maker code", got, flash_dev_model_inst.MAKER_CODE);
    req(OP_ID_READ, 20'h00001, 16'h0000, 1'b0, 16'd0);
    chk("part code", got, flash_dev_model_inst.PART_CODE);
    chk("id mode left", flash_dev_model_inst.id_mode, 1'b0);
    req(OP_READ, 20'h12345, 16'h0000, 1'b0, 16'd0);
    chk("array after id", got, 16'hffff);
  endtask : t_id
  task automatic t_lock();
    chk("lockdown before", flash_dev_model_inst.lock_en, 1'b0);
    req(OP_LOCKDOWN, 20'h00000, 16'h0000, 1'b0, 16'd0);
    chk("lockdown after", flash_dev_model_inst.lock_en, 1'b1);
  endtask : t_lock
  initial begin
    do_reset();
    t_program();
    t_dual();
    t_sector();
    t_chip();
    t_id();
    t_lock();
    chk("read strobe during write", flash_dev_model_inst.viol_oe, 0);
    chk("read inside command", flash_dev_model_inst.viol_seq, 0);
    chk("poll address moved", flash_dev_model_inst.viol_addr, 0);
    final_report();
  end
  initial begin
    #(60000 * 50);
    error_cnt++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end
endmodule : test_flash_host_ctrl
